// file: rtl/wcf_regs.vh
`ifndef WCF_REGS_VH
`define WCF_REGS_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define WCF_OFS_WAKE_CONTROL 16'h5800
`define WCF_OFS_WAKE_FILTER_ENABLE 16'h5808
`define WCF_OFS_WAKE_STATUS 16'h5810
`define WCF_OFS_IRQ_STATUS 16'h5880
`define WCF_OFS_IRQ_MASK 16'h5884

// ------------------------------------------------------------
// Wake control fields
// ------------------------------------------------------------
`define WCF_WC_APM_WAKE_EN 0
`define WCF_WC_PM_EVENT_ENABLE 1
`define WCF_WC_PM_EVENT_FLAG 2
`define WCF_WC_APM_ASSERT_WAKE 3
`define WCF_WC_LINK_CHANGE_APM_WAKE_EN 4
`define WCF_WC_LINK_CHANGE_APM_OVERRIDE 5
`define WCF_WC_TCO1_ALLOC_FOR_WAKE 6
`define WCF_WC_TCO1_WAKE_FILTER_EN 7
`define WCF_WC_TCO0_ALLOC_FOR_WAKE 8
`define WCF_WC_TCO0_WAKE_FILTER_EN 9
`define WCF_WC_RESET 10'h000

// ------------------------------------------------------------
// Wake filter enable fields
// ------------------------------------------------------------
`define WCF_WF_LINK_CHANGE_WAKE_EN 0
`define WCF_WF_WAKE_PATTERN_FRAME_EN 1
`define WCF_WF_IGNORE_MGMT_PACKETS 15
`define WCF_WF_FLEX_LSB 16
`define WCF_WF_MASK 32'h000F80FF
`define WCF_WF_RESET 32'h00000000

// ------------------------------------------------------------
// Wake status fields and mask
// ------------------------------------------------------------
`define WCF_WS_LINK_CHANGE 0
`define WCF_WS_TCO0 9
`define WCF_WS_TCO1 10
`define WCF_WS_MASK 32'h000F06FF
`define WCF_WS_RESET 32'h00000000

// ------------------------------------------------------------
// Interrupt status bits
// ------------------------------------------------------------
`define WCF_IRQ_WAKE_EVENT 0
`define WCF_IRQ_WAKE_STATUS 1
`define WCF_IRQ_RESET 2'h0

`endif

// file: rtl/wcf_top.v
`timescale 1ns/100ps
// Behaviour
// - Event enable and event flag clear while internal power-on reset is low.
// - Event enable and event flag also clear on rising edge of bus reset.
// - Other wake control bits reset only by the standard internal reset.
// - Bit 0 enables advanced power-management wake; loaded from nonvolatile memory.
// - Bit 1 is a read/write alias of the config-space event enable.
// - Bit 2 sets on wake event, mirrors config flag, write one clears.
// - Bit 3 with APM wake: pattern frame sets flag and drives wake output.
// - Bit 4 enables wake on link status change under APM.
// - Bit 5 makes APM settings govern link wake; loaded from nonvolatile memory.
// - Bit 6 allocates flexible manageability filter 1 to wake or manageability.
// - Bit 7 enables filter 1 for wake, only while bit 6 allocates it.
// - Bit 8 allocates filter 0; bit 9 enables it, only while allocated.
// - Filter bits 0 to 7 enable the predefined wake filters in order.
// - Filter bits 16 to 19 enable flexible wake filters 0 to 3.
// - Each filter enable bit turns its filter on at 1, off at 0.
// - Bit 15 set: packets passing manageability filtering never cause a wake event.
// - Matching criteria of each wake packet are recorded; write one clears.
`include "wcf_regs.vh"

module wcf_top #(
   parameter ADDR_W = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire por_n,
   input wire pci_rst_n,
   input wire nvm_load,
   input wire nvm_apm_wake_en,
   input wire nvm_link_change_apm_override,
   input wire cfg_pm_event_enable_wr,
   input wire cfg_pm_event_enable_data,
   input wire cfg_pm_event_flag_clr,
   input wire rx_pkt_valid,
   input wire [19:0] rx_pkt_match,
   input wire rx_pkt_mgmt,
   input wire link_change,
   output reg pm_event_enable,
   output reg pm_event_flag,
   output reg wake_out_n,
   output reg irq
);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function addr_hit;
      input [ADDR_W-1:0] a;
      input [15:0] ofs;
      begin
         addr_hit = (a[15:0] == ofs);
      end
   endfunction

   // Write-one-to-clear with set winning over clear
   function [31:0] w1c_set;
      input [31:0] cur;
      input [31:0] clr;
      input [31:0] set;
      begin
         w1c_set = (cur & ~clr) | set;
      end
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   reg por_meta;
   reg por_sync;
   reg pci_meta;
   reg pci_sync;
   reg pci_sync_d;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_meta <= 1'b0;
         por_sync <= 1'b0;
         // Idle level of the bus reset pin, so leaving presetn shows no false rise
         pci_meta <= 1'b1;
         pci_sync <= 1'b1;
         pci_sync_d <= 1'b1;
      end else begin
         por_meta <= por_n;
         por_sync <= por_meta;
         pci_meta <= pci_rst_n;
         pci_sync <= pci_meta;
         pci_sync_d <= pci_sync;
      end
   end

   wire por_low = ~por_sync;
   // Deepest unpowered sleep is unsupported, so bus reset release also clears
   wire pci_rise = pci_sync & ~pci_sync_d;
   wire pm_clear = por_low | pci_rise;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire acc = psel & penable;
   wire done = acc & pready;
   wire wr_done = done & pwrite;
   wire hit_wc = addr_hit(paddr, `WCF_OFS_WAKE_CONTROL);
   wire hit_wf = addr_hit(paddr, `WCF_OFS_WAKE_FILTER_ENABLE);
   wire hit_ws = addr_hit(paddr, `WCF_OFS_WAKE_STATUS);
   wire hit_is = addr_hit(paddr, `WCF_OFS_IRQ_STATUS);
   wire hit_im = addr_hit(paddr, `WCF_OFS_IRQ_MASK);
   wire hit_any = hit_wc | hit_wf | hit_ws | hit_is | hit_im;
   wire wr_wc = wr_done & hit_wc;
   wire wr_wf = wr_done & hit_wf;
   wire wr_ws = wr_done & hit_ws;
   wire wr_is = wr_done & hit_is;
   wire wr_im = wr_done & hit_im;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg apm_wake_en;
   reg apm_assert_wake;
   reg link_change_apm_wake_en;
   reg link_change_apm_override;
   reg tco1_alloc_for_wake;
   reg tco1_wake_filter_en;
   reg tco0_alloc_for_wake;
   reg tco0_wake_filter_en;
   reg [31:0] wake_filter_enable;
   reg [31:0] wake_status;
   reg [1:0] irq_status;
   reg [1:0] irq_mask;

   // ------------------------------------------------------------
   // Wake qualification
   // ------------------------------------------------------------
   wire tco0_on = tco0_alloc_for_wake & tco0_wake_filter_en;
   wire tco1_on = tco1_alloc_for_wake & tco1_wake_filter_en;
   wire [31:0] pkt_enables;
   // Flexible filter enables are gated one for one
   assign pkt_enables = {12'h000,
                         wake_filter_enable[`WCF_WF_FLEX_LSB+3:`WCF_WF_FLEX_LSB],
                         5'h00, tco1_on, tco0_on, 1'b0,
                         wake_filter_enable[7:1], 1'b0};
   wire [31:0] pkt_hits = {12'h000, rx_pkt_match} & pkt_enables;
   wire mgmt_block = wake_filter_enable[`WCF_WF_IGNORE_MGMT_PACKETS] & rx_pkt_mgmt;
   wire pkt_wake = rx_pkt_valid & (|pkt_hits) & ~mgmt_block;

   // Override moves link wake from the filter bit to the APM settings
   wire link_en = link_change_apm_override ?
                  (apm_wake_en & link_change_apm_wake_en) :
                  wake_filter_enable[`WCF_WF_LINK_CHANGE_WAKE_EN];
   wire link_wake = link_change & link_en;

   // APM pattern-frame wake ignores the filter enables except bit 15, which still blocks manageability packets
   wire apm_wake = rx_pkt_valid & rx_pkt_match[`WCF_WF_WAKE_PATTERN_FRAME_EN] &
                   apm_wake_en & apm_assert_wake & ~mgmt_block;
   wire wake_event = pkt_wake | link_wake | apm_wake;

   wire [31:0] status_set = ({32{pkt_wake}} & pkt_hits) |
                            ({31'h0, link_wake} << `WCF_WS_LINK_CHANGE) |
                            ({32{apm_wake}} & (32'h1 << `WCF_WF_WAKE_PATTERN_FRAME_EN));

   // ------------------------------------------------------------
   // Wake control, standard reset domain
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apm_wake_en <= 1'b0;
         apm_assert_wake <= 1'b0;
         link_change_apm_wake_en <= 1'b0;
         link_change_apm_override <= 1'b0;
         tco1_alloc_for_wake <= 1'b0;
         tco1_wake_filter_en <= 1'b0;
         tco0_alloc_for_wake <= 1'b0;
         tco0_wake_filter_en <= 1'b0;
      end else begin
         if (wr_wc) begin
            apm_wake_en <= pwdata[`WCF_WC_APM_WAKE_EN];
            apm_assert_wake <= pwdata[`WCF_WC_APM_ASSERT_WAKE];
            link_change_apm_wake_en <= pwdata[`WCF_WC_LINK_CHANGE_APM_WAKE_EN];
            link_change_apm_override <= pwdata[`WCF_WC_LINK_CHANGE_APM_OVERRIDE];
            tco1_alloc_for_wake <= pwdata[`WCF_WC_TCO1_ALLOC_FOR_WAKE];
            tco1_wake_filter_en <= pwdata[`WCF_WC_TCO1_WAKE_FILTER_EN];
            tco0_alloc_for_wake <= pwdata[`WCF_WC_TCO0_ALLOC_FOR_WAKE];
            tco0_wake_filter_en <= pwdata[`WCF_WC_TCO0_WAKE_FILTER_EN];
         end else if (nvm_load) begin
            // Initialisation load; a software write in the same cycle wins
            apm_wake_en <= nvm_apm_wake_en;
            link_change_apm_override <= nvm_link_change_apm_override;
         end
      end
   end

   // ------------------------------------------------------------
   // Event enable and flag, also cleared by the power resets
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_event_enable <= 1'b0;
         pm_event_flag <= 1'b0;
      end else if (pm_clear) begin
         pm_event_enable <= 1'b0;
         pm_event_flag <= 1'b0;
      end else begin
         if (wr_wc) begin
            pm_event_enable <= pwdata[`WCF_WC_PM_EVENT_ENABLE];
         end else if (cfg_pm_event_enable_wr) begin
            pm_event_enable <= cfg_pm_event_enable_data;
         end
         // A wake arriving with a clear keeps the flag set
         if (wake_event) begin
            pm_event_flag <= 1'b1;
         end else if ((wr_wc & pwdata[`WCF_WC_PM_EVENT_FLAG]) | cfg_pm_event_flag_clr) begin
            pm_event_flag <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Filter enable and wake status
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_filter_enable <= `WCF_WF_RESET;
      end else if (wr_wf) begin
         wake_filter_enable <= pwdata & `WCF_WF_MASK;
      end
   end

   // Bus reset does not touch the record; power-on reset clears it, as does presetn
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_status <= `WCF_WS_RESET;
      end else if (por_low) begin
         wake_status <= `WCF_WS_RESET;
      end else begin
         wake_status <= w1c_set(wake_status,
                                {32{wr_ws}} & pwdata,
                                status_set) & `WCF_WS_MASK;
      end
   end

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   wire [1:0] irq_set = {(|status_set), wake_event};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= `WCF_IRQ_RESET;
         irq_mask <= `WCF_IRQ_RESET;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~({2{wr_is}} & pwdata[1:0])) | irq_set;
         if (wr_im) begin
            irq_mask <= pwdata[1:0];
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // ------------------------------------------------------------
   // Wake pin
   // ------------------------------------------------------------
   // Asserted while the flag stands and either config enable or APM asks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_out_n <= 1'b1;
      end else begin
         wake_out_n <= ~(pm_event_flag & (pm_event_enable |
                         (apm_wake_en & apm_assert_wake)));
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   reg [31:0] rd_val;

   always @* begin
      rd_val = 32'h00000000;
      if (hit_wc) begin
         rd_val[`WCF_WC_APM_WAKE_EN] = apm_wake_en;
         rd_val[`WCF_WC_PM_EVENT_ENABLE] = pm_event_enable;
         rd_val[`WCF_WC_PM_EVENT_FLAG] = pm_event_flag;
         rd_val[`WCF_WC_APM_ASSERT_WAKE] = apm_assert_wake;
         rd_val[`WCF_WC_LINK_CHANGE_APM_WAKE_EN] = link_change_apm_wake_en;
         rd_val[`WCF_WC_LINK_CHANGE_APM_OVERRIDE] = link_change_apm_override;
         rd_val[`WCF_WC_TCO1_ALLOC_FOR_WAKE] = tco1_alloc_for_wake;
         rd_val[`WCF_WC_TCO1_WAKE_FILTER_EN] = tco1_wake_filter_en;
         rd_val[`WCF_WC_TCO0_ALLOC_FOR_WAKE] = tco0_alloc_for_wake;
         rd_val[`WCF_WC_TCO0_WAKE_FILTER_EN] = tco0_wake_filter_en;
      end else if (hit_wf) begin
         rd_val = wake_filter_enable & `WCF_WF_MASK;
      end else if (hit_ws) begin
         rd_val = wake_status & `WCF_WS_MASK;
      end else if (hit_is) begin
         rd_val[1:0] = irq_status;
      end else if (hit_im) begin
         rd_val[1:0] = irq_mask;
      end
   end

   // ------------------------------------------------------------
   // Bus answer: one wait state, then ready for one cycle
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= acc & ~pready;
         pslverr <= acc & ~pready & ~hit_any;
         if (acc & ~pready & ~pwrite) begin
            prdata <= rd_val;
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

endmodule

// file: verification/wcf_chk_sva.sv
`timescale 1ns/100ps
`include "wcf_regs.vh"
module wcf_chk #(
   parameter ADDR_W = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire por_n,
   input wire pci_rst_n,
   input wire cfg_pm_event_enable_wr,
   input wire cfg_pm_event_enable_data,
   input wire cfg_pm_event_flag_clr,
   input wire rx_pkt_valid,
   input wire link_change,
   input wire pm_event_enable,
   input wire pm_event_flag,
   input wire wake_out_n
);
   wire mapped;
   assign mapped = paddr == `WCF_OFS_WAKE_CONTROL || paddr == `WCF_OFS_WAKE_FILTER_ENABLE ||
      paddr == `WCF_OFS_WAKE_STATUS || paddr == `WCF_OFS_IRQ_STATUS ||
      paddr == `WCF_OFS_IRQ_MASK;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc; psel && penable && !pready; endsequence
   sequence s_por_lo; !por_n [*4]; endsequence
   sequence s_por_hi; por_n [*3]; endsequence
   sequence s_evt_off; !pm_event_enable && !pm_event_flag; endsequence
   property p_rdy_wait; s_acc |=> pready; endproperty
   a_rdy_wait: assert property (p_rdy_wait) else $error("pready missing after wait");
   property p_rdy_pulse; pready |=> !pready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than a cycle");
   property p_err_map; pready |-> pslverr == !mapped; endproperty
   a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
   property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("prdata not zero when idle");
   property p_por_clr; s_por_lo |=> s_evt_off; endproperty
   a_por_clr: assert property (p_por_clr) else $error("event bits kept in por");
   property p_pci_clr; $rose(pci_rst_n) |-> ##[1:5] s_evt_off; endproperty
   a_pci_clr: assert property (p_pci_clr) else $error("event bits kept on pci rise");
   property p_cfg_en;
      s_por_hi ##0 (cfg_pm_event_enable_wr && !psel && pci_rst_n) |=>
         pm_event_enable == $past(cfg_pm_event_enable_data);
   endproperty
   a_cfg_en: assert property (p_cfg_en) else $error("event enable alias wrong");
   property p_flag_clr; cfg_pm_event_flag_clr && !rx_pkt_valid && !link_change |=> !pm_event_flag;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("event flag not cleared");
   property p_wake_on; pm_event_flag && pm_event_enable |=> !wake_out_n; endproperty
   a_wake_on: assert property (p_wake_on) else $error("wake pin not driven");
   property p_wake_off; !pm_event_flag |=> wake_out_n; endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake pin without event");
endmodule
bind wcf_top wcf_chk #(.ADDR_W(ADDR_W)) chk_u (.*);

// file: verification/wcf_host_model.sv
`timescale 1ns/100ps
module wcf_host_model (
   input wire logic pclk,
   output logic por_n = 1'b1,
   output logic pci_rst_n = 1'b1,
   output logic nvm_load = 1'b0,
   output logic nvm_apm_wake_en = 1'b0,
   output logic nvm_link_change_apm_override = 1'b0,
   output logic cfg_pm_event_enable_wr = 1'b0,
   output logic cfg_pm_event_enable_data = 1'b0,
   output logic cfg_pm_event_flag_clr = 1'b0
);
   // Data lines show the inverse once released so stale values never look valid
   task cfg_en(input logic v);
      @(posedge pclk);
      cfg_pm_event_enable_wr <= 1'b1;
      cfg_pm_event_enable_data <= v;
      @(posedge pclk);
      cfg_pm_event_enable_wr <= 1'b0;
      cfg_pm_event_enable_data <= !v;
   endtask
   task cfg_clr;
      @(posedge pclk);
      cfg_pm_event_flag_clr <= 1'b1;
      @(posedge pclk);
      cfg_pm_event_flag_clr <= 1'b0;
   endtask
   task nvm(input logic a, input logic o);
      @(posedge pclk);
      nvm_load <= 1'b1;
      nvm_apm_wake_en <= a;
      nvm_link_change_apm_override <= o;
      @(posedge pclk);
      nvm_load <= 1'b0;
      nvm_apm_wake_en <= !a;
      nvm_link_change_apm_override <= !o;
   endtask
   // Pulse power-on reset (0) or bus reset (1) low; wait out the synchroniser
   task low(input logic which, input int n);
      @(posedge pclk);
      if (which) pci_rst_n <= 1'b0;
      else por_n <= 1'b0;
      repeat (n) @(posedge pclk);
      pci_rst_n <= 1'b1;
      por_n <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask
endmodule

// file: verification/wcf_top_tb_top.sv
`timescale 1ns/100ps
`include "wcf_regs.vh"
module wcf_top_tb_top;
   localparam logic [15:0] a_wc = `WCF_OFS_WAKE_CONTROL;
   localparam logic [15:0] a_wf = `WCF_OFS_WAKE_FILTER_ENABLE;
   localparam logic [15:0] a_ws = `WCF_OFS_WAKE_STATUS;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic rx_pkt_valid = 1'b0, rx_pkt_mgmt = 1'b0, link_change = 1'b0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0, prdata, wc, d;
   logic [19:0] rx_pkt_match = 20'h0;
   logic pready, pslverr, pm_event_enable, pm_event_flag, wake_out_n, irq;
   logic por_n, pci_rst_n, nvm_load, nvm_apm_wake_en, nvm_link_change_apm_override;
   logic cfg_pm_event_enable_wr, cfg_pm_event_enable_data, cfg_pm_event_flag_clr;
   logic [32:0] exp_q[$];
   int error_cnt = 0, checked = 0, seed = 69;
   int pb[11] = '{1, 2, 3, 4, 5, 6, 7, 16, 17, 18, 19};
   wcf_top dut_u (.*);
   wcf_host_model host_u (.*);
   always #25 pclk = ~pclk;
   task check(input string n, input logic [32:0] s, input logic [32:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task final_report;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Answers are compared where they appear, against notes queued by the driver
   always @(posedge pclk) if (psel && penable && pready) begin
      if (exp_q.size() == 0) check("extra answer", 33'h1, 33'h0);
      else check("apb answer", {pslverr, prdata}, exp_q.pop_front());
   end
   task apb(input logic w, input logic [15:0] a, input logic [31:0] wd, input logic [32:0] e);
      int n;
      exp_q.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~wd;
      if (n >= 50) begin
         check("pready timeout", 33'h1, 33'h0);
         final_report();
      end
   endtask
   task wr(input logic [15:0] a, input logic [31:0] v);
      apb(1'b1, a, v, 33'h0);
   endtask
   task rd(input logic [15:0] a, input logic [31:0] v);
      apb(1'b0, a, 32'h0, {1'b0, v});
   endtask
   task setwc(input logic [31:0] v);
      wc = v;
      wr(a_wc, v);
   endtask
   task pk(input logic l, input logic [19:0] m, input logic g);
      @(posedge pclk);
      link_change <= l;
      rx_pkt_valid <= !l;
      rx_pkt_match <= m;
      rx_pkt_mgmt <= g;
      @(posedge pclk);
      link_change <= 1'b0;
      rx_pkt_valid <= 1'b0;
      rx_pkt_match <= ~m;
   endtask
   task ev(input logic l, input logic [19:0] m, input logic g, input logic f, input logic wk);
      pk(l, m, g);
      @(negedge pclk);
      check("event flag", {32'h0, pm_event_flag}, {32'h0, f});
      @(negedge pclk);
      check("wake pin", {32'h0, wake_out_n}, {32'h0, !wk});
      if (f) rd(a_ws, {12'h0, m});
      wr(a_ws, 32'hFFFFFFFF);
      wr(a_wc, wc | 32'h4);
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      check("watchdog", 33'h1, 33'h0);
      final_report();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      rd(a_wc, 32'h0);
      rd(a_wf, 32'h0);
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         setwc(d);
         rd(a_wc, d & 32'h3FB);
         check("enable alias", {32'h0, pm_event_enable}, {32'h0, d[1]});
         wr(a_wf, d);
         rd(a_wf, d & `WCF_WF_MASK);
      end
      apb(1'b0, 16'h5804, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 16'h5804, d, {1'b1, 32'h0});
      setwc(32'h2);
      foreach (pb[k]) begin
         wr(a_wf, 32'h0);
         ev(1'b0, 20'h1 << pb[k], 1'b0, 1'b0, 1'b0);
         wr(a_wf, 32'h1 << pb[k]);
         ev(1'b0, 20'h1 << pb[k], 1'b0, 1'b1, 1'b1);
      end
      wr(a_wf, 32'h8004);
      ev(1'b0, 20'h4, 1'b1, 1'b0, 1'b0);
      ev(1'b0, 20'h4, 1'b0, 1'b1, 1'b1);
      wr(a_wf, 32'h0);
      for (int t = 0; t < 2; t++) begin
         setwc(32'h2 | (32'h2 << (8 - 2 * t)));
         ev(1'b0, 20'h200 << t, 1'b0, 1'b0, 1'b0);
         setwc(32'h2 | (32'h1 << (8 - 2 * t)));
         ev(1'b0, 20'h200 << t, 1'b0, 1'b0, 1'b0);
         setwc(32'h2 | (32'h3 << (8 - 2 * t)));
         ev(1'b0, 20'h200 << t, 1'b0, 1'b1, 1'b1);
      end
      wr(a_wf, 32'h1);
      setwc(32'h2);
      ev(1'b1, 20'h1, 1'b0, 1'b1, 1'b1);
      setwc(32'h22);
      ev(1'b1, 20'h1, 1'b0, 1'b0, 1'b0);
      wr(a_wf, 32'h0);
      setwc(32'h33);
      ev(1'b1, 20'h1, 1'b0, 1'b1, 1'b1);
      setwc(32'h0);
      host_u.nvm(1'b1, 1'b1);
      rd(a_wc, 32'h21);
      setwc(32'h9);
      ev(1'b0, 20'h2, 1'b0, 1'b1, 1'b1);
      setwc(32'h1);
      ev(1'b0, 20'h2, 1'b0, 1'b0, 1'b0);
      setwc(32'h3C0);
      host_u.cfg_en(1'b1);
      wr(a_wf, 32'h4);
      pk(1'b0, 20'h4, 1'b0);
      rd(a_wc, 32'h3C6);
      host_u.cfg_clr();
      rd(a_wc, 32'h3C2);
      wr(`WCF_OFS_IRQ_STATUS, 32'h3);
      wr(`WCF_OFS_IRQ_MASK, 32'h0);
      pk(1'b0, 20'h4, 1'b0);
      repeat (2) @(negedge pclk);
      check("irq masked", {32'h0, irq}, 33'h0);
      wr(`WCF_OFS_IRQ_MASK, 32'h1);
      repeat (2) @(negedge pclk);
      check("irq raised", {32'h0, irq}, 33'h1);
      wr(`WCF_OFS_IRQ_STATUS, 32'h3);
      repeat (2) @(negedge pclk);
      check("irq cleared", {32'h0, irq}, 33'h0);
      host_u.low(1'b0, 5);
      rd(a_wc, 32'h3C0);
      host_u.cfg_en(1'b1);
      pk(1'b0, 20'h4, 1'b0);
      host_u.low(1'b1, 2);
      rd(a_wc, 32'h3C0);
      final_report();
   end
endmodule
